//--- include/perc_pkg.sv
// constants and types for the error reporting and serial number capability registers
// ****************************************************************************
// Overview of operation
// - masked uncorrectable error sends no message
// - uncorrectable mask bits at 4, 12-18, 20
// - uncorrectable mask bits sticky, reset to zero
// - severity one means fatal, zero non-fatal
// - severity sticky; 4,13,17,18 reset one
// - hardware sets correctable status bits on error
// - correctable status sticky, cleared by writing one
// - correctable mask bit suppresses its message
// - advisory mask bit 13 resets to one
// - four-bit first error pointer, read only
// - 128-bit header log captures failing header
// - 64-bit serial number, lower dword first
// - serial capability lives in function zero
// - serial capability id reads 0003h
// - serial header: next, version, id fields
// - capabilities at 0x100 and 0x140
// - error next pointer 0x140 or 0x000
// ****************************************************************************
package perc_pkg;

   // ************************************************************************
   // configuration space offsets (byte addresses)
   // ************************************************************************
   localparam logic [11:0] AER_BASE = 12'h100; // error reporting capability
   localparam logic [11:0] DSN_BASE = 12'h140; // serial number capability
   localparam logic [11:0] OFS_CAP_HDR = 12'h000; // capability header
   localparam logic [11:0] OFS_UNC_MASK = 12'h008;
   localparam logic [11:0] OFS_UNC_SEV = 12'h00c;
   localparam logic [11:0] OFS_COR_STAT = 12'h010;
   localparam logic [11:0] OFS_COR_MASK = 12'h014;
   localparam logic [11:0] OFS_FEP = 12'h018;
   localparam logic [11:0] OFS_HLOG = 12'h01c; // four dwords from here
   localparam logic [11:0] OFS_DSN_LO = 12'h004;
   localparam logic [11:0] OFS_DSN_HI = 12'h008;
   localparam int HLOG_DWORDS = 4;

   // ************************************************************************
   // implemented bits and reset values
   // ************************************************************************
   localparam logic [31:0] UNC_IMPL = 32'h0017f010; // bits 4, 12..18, 20
   localparam logic [31:0] UNC_MASK_RST = 32'h00000000;
   localparam logic [31:0] UNC_SEV_RST = 32'h00062010; // bits 4, 13, 17, 18
   localparam logic [31:0] COR_IMPL = 32'h000031c1; // bits 0, 6, 7, 8, 12, 13
   localparam logic [31:0] COR_STAT_RST = 32'h00000000;
   localparam logic [31:0] COR_MASK_RST = 32'h00002000; // advisory masked
   localparam logic [3:0] FEP_RST = 4'h0;

   // ************************************************************************
   // capability header fields
   // ************************************************************************
   localparam int HDR_NEXT_LSB = 20; // next offset in 31:20
   localparam int HDR_VER_LSB = 16; // version in 19:16
   localparam logic [15:0] AER_CAP_ID = 16'h0001;
   localparam logic [15:0] DSN_CAP_ID = 16'h0003;
   localparam logic [3:0] CAP_VERSION = 4'h1;
   localparam logic [11:0] NEXT_NONE = 12'h000;

   // kind of error message sent to the host bridge
   typedef enum logic [1:0] {
      MSG_COR = 2'b00,
      MSG_NONFATAL = 2'b01,
      MSG_FATAL = 2'b10
   } perc_msg_t;

endpackage

//--- rtl/perc_top.sv
// error reporting and serial number capability register bank
`timescale 1ns/100ps
module perc_top (
   // clock and power-on reset
   input wire logic mclk,
   input wire logic arst_n,
   // function or link reset, non-sticky state only
   input wire logic func_rst,
   // configuration access from the root complex
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [11:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rd_valid,
   // error sources
   input wire logic [31:0] unc_err_evt,
   input wire logic [31:0] cor_err_evt,
   input wire logic [127:0] err_hdr,
   input wire logic fep_release,
   // serial number source and nonvolatile enable
   input wire logic [63:0] serial_num,
   input wire logic dsn_enable_pin,
   // error message request to the transport
   output logic err_msg_valid,
   output perc_pkg::perc_msg_t err_msg_kind
);

   // ************************************************************************
   // helper functions
   // ************************************************************************

   // expands byte enables into a bit mask
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction

   // lowest set bit position of an event vector
   function automatic logic [4:0] first_pos(input logic [31:0] v);
      logic [4:0] p;
      p = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            p = 5'(i);
         end
      end
      return p;
   endfunction

   // decodes a dword address against base plus offset
   function automatic logic hit(input logic [11:0] a, input logic [11:0] base,
                                input logic [11:0] ofs);
      return a[11:2] == 10'((base + ofs) >> 2);
   endfunction

   // ************************************************************************
   // state
   // ************************************************************************
   logic [31:0] unc_mask_reg; // sticky
   logic [31:0] unc_sev_reg; // sticky
   logic [31:0] cor_stat_reg; // sticky, write one to clear
   logic [31:0] cor_mask_reg; // sticky
   logic [3:0] fep_reg; // first error pointer
   logic fep_lock_reg; // pointer holds a recorded error
   logic [127:0] hlog_reg; // header log
   logic dsn_sync1_reg; // synchroniser first stage
   logic dsn_en_reg; // synchronised enable
   logic [31:0] wmask; // bytes written this cycle
   logic [31:0] unc_live; // implemented uncorrectable events
   logic [31:0] unc_rep; // unmasked uncorrectable events
   logic [31:0] cor_live; // implemented correctable events
   logic [4:0] fep_pos; // lowest live uncorrectable position
   logic [31:0] rdata_next;
   logic [31:0] aer_hdr;
   logic [31:0] dsn_hdr;

   assign wmask = cfg_wr ? be_mask(cfg_be) : 32'h00000000;
   assign unc_live = unc_err_evt & perc_pkg::UNC_IMPL;
   assign unc_rep = unc_live & ~unc_mask_reg;
   assign cor_live = cor_err_evt & perc_pkg::COR_IMPL;
   assign fep_pos = first_pos(unc_live);

   // ************************************************************************
   // nonvolatile serial enable, two-stage synchroniser
   // ************************************************************************
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dsn_sync1_reg <= 1'b0;
         dsn_en_reg <= 1'b0;
      end else begin
         dsn_sync1_reg <= dsn_enable_pin;
         dsn_en_reg <= dsn_sync1_reg;
      end
   end

   // ************************************************************************
   // sticky mask and severity registers
   // ************************************************************************

   // only power-on reset touches these; func_rst deliberately ignored
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         unc_mask_reg <= perc_pkg::UNC_MASK_RST;
         unc_sev_reg <= perc_pkg::UNC_SEV_RST;
         cor_mask_reg <= perc_pkg::COR_MASK_RST;
      end else begin
         // reserved bits are kept out by the implemented masks
         if (hit(cfg_addr, perc_pkg::AER_BASE, perc_pkg::OFS_UNC_MASK)) begin
            unc_mask_reg <= (unc_mask_reg & ~wmask) |
                            (cfg_wdata & wmask & perc_pkg::UNC_IMPL);
         end
         if (hit(cfg_addr, perc_pkg::AER_BASE, perc_pkg::OFS_UNC_SEV)) begin
            unc_sev_reg <= (unc_sev_reg & ~wmask) |
                           (cfg_wdata & wmask & perc_pkg::UNC_IMPL);
         end
         if (hit(cfg_addr, perc_pkg::AER_BASE, perc_pkg::OFS_COR_MASK)) begin
            cor_mask_reg <= (cor_mask_reg & ~wmask) |
                            (cfg_wdata & wmask & perc_pkg::COR_IMPL);
         end
      end
   end

   // ************************************************************************
   // correctable status, set wins over clear
   // ************************************************************************
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cor_stat_reg <= perc_pkg::COR_STAT_RST;
      end else if (hit(cfg_addr, perc_pkg::AER_BASE, perc_pkg::OFS_COR_STAT)) begin
         // a one clears, a zero leaves the bit alone
         cor_stat_reg <= (cor_stat_reg & ~(cfg_wdata & wmask)) | cor_live;
      end else begin
         cor_stat_reg <= cor_stat_reg | cor_live;
      end
   end

   // ************************************************************************
   // first error pointer and header log
   // ************************************************************************

   // the first error locks both until the status owner releases it;
   // masked errors are still recorded, only reporting is suppressed
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         fep_reg <= perc_pkg::FEP_RST;
         fep_lock_reg <= 1'b0;
         hlog_reg <= '0;
      end else if (func_rst) begin
         fep_reg <= perc_pkg::FEP_RST;
         fep_lock_reg <= 1'b0;
         hlog_reg <= '0;
      end else if (!fep_lock_reg && (|unc_live)) begin
         fep_reg <= fep_pos[3:0];
         fep_lock_reg <= 1'b1;
         hlog_reg <= err_hdr;
      end else if (fep_release) begin
         fep_lock_reg <= 1'b0;
      end
   end

   // ************************************************************************
   // error message request
   // ************************************************************************

   // one message a cycle; fatal outranks non-fatal outranks correctable
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         err_msg_valid <= 1'b0;
         err_msg_kind <= perc_pkg::MSG_COR;
      end else if (func_rst) begin
         err_msg_valid <= 1'b0;
         err_msg_kind <= perc_pkg::MSG_COR;
      end else if (|(unc_rep & unc_sev_reg)) begin
         err_msg_valid <= 1'b1;
         err_msg_kind <= perc_pkg::MSG_FATAL;
      end else if (|(unc_rep & ~unc_sev_reg)) begin
         err_msg_valid <= 1'b1;
         err_msg_kind <= perc_pkg::MSG_NONFATAL;
      end else if (|(cor_live & ~cor_mask_reg)) begin
         err_msg_valid <= 1'b1;
         err_msg_kind <= perc_pkg::MSG_COR;
      end else begin
         err_msg_valid <= 1'b0;
      end
   end

   // ************************************************************************
   // read path
   // ************************************************************************

   // next pointer follows the nonvolatile enable
   assign aer_hdr = {(dsn_en_reg ? perc_pkg::DSN_BASE : perc_pkg::NEXT_NONE),
                     perc_pkg::CAP_VERSION, perc_pkg::AER_CAP_ID};
   // last capability in the list
   assign dsn_hdr = {perc_pkg::NEXT_NONE, perc_pkg::CAP_VERSION,
                     perc_pkg::DSN_CAP_ID};

   // single function part, so no function number is decoded here
   always_comb begin
      rdata_next = 32'h00000000; // unmapped and uncorrectable status read zero
      if (hit(cfg_addr, perc_pkg::AER_BASE, perc_pkg::OFS_CAP_HDR)) begin
         rdata_next = aer_hdr;
      end else if (hit(cfg_addr, perc_pkg::AER_BASE, perc_pkg::OFS_UNC_MASK)) begin
         rdata_next = unc_mask_reg;
      end else if (hit(cfg_addr, perc_pkg::AER_BASE, perc_pkg::OFS_UNC_SEV)) begin
         rdata_next = unc_sev_reg;
      end else if (hit(cfg_addr, perc_pkg::AER_BASE, perc_pkg::OFS_COR_STAT)) begin
         rdata_next = cor_stat_reg;
      end else if (hit(cfg_addr, perc_pkg::AER_BASE, perc_pkg::OFS_COR_MASK)) begin
         rdata_next = cor_mask_reg;
      end else if (hit(cfg_addr, perc_pkg::AER_BASE, perc_pkg::OFS_FEP)) begin
         rdata_next = {28'h0000000, fep_reg};
      end else if (dsn_en_reg && hit(cfg_addr, perc_pkg::DSN_BASE,
                                     perc_pkg::OFS_CAP_HDR)) begin
         rdata_next = dsn_hdr;
      end else if (dsn_en_reg && hit(cfg_addr, perc_pkg::DSN_BASE,
                                     perc_pkg::OFS_DSN_LO)) begin
         rdata_next = serial_num[31:0];
      end else if (dsn_en_reg && hit(cfg_addr, perc_pkg::DSN_BASE,
                                     perc_pkg::OFS_DSN_HI)) begin
         rdata_next = serial_num[63:32];
      end
      // header log, dword 0 holds bits 31:0
      for (int i = 0; i < perc_pkg::HLOG_DWORDS; i++) begin
         if (hit(cfg_addr, perc_pkg::AER_BASE, 12'(perc_pkg::OFS_HLOG + 12'(i * 4)))) begin
            rdata_next = hlog_reg[i*32 +: 32];
         end
      end
   end

   // read data registered, valid one cycle after the request
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_rdata <= 32'h00000000;
         cfg_rd_valid <= 1'b0;
      end else begin
         cfg_rd_valid <= cfg_rd;
         if (cfg_rd) begin
            cfg_rdata <= rdata_next;
         end
      end
   end

   // ************************************************************************
   // assertions
   // ************************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   sequence unc_fatal_s;
      (|(unc_err_evt & perc_pkg::UNC_IMPL & ~unc_mask_reg & unc_sev_reg)) && !func_rst;
   endsequence

   sequence fatal_msg_s;
      err_msg_valid && (err_msg_kind == perc_pkg::MSG_FATAL);
   endsequence

   unc_mask_silent_a: assert property (
      (unc_live != 32'h0) && ((unc_live & ~unc_mask_reg) == 32'h0) &&
      ((cor_live & ~cor_mask_reg) == 32'h0) |=> !err_msg_valid)
      else $error("masked error produced a message");

   fatal_report_a: assert property (unc_fatal_s |=> fatal_msg_s)
      else $error("fatal error not reported as fatal");

   resv_bits_zero_a: assert property (
      ((unc_mask_reg | unc_sev_reg) & ~perc_pkg::UNC_IMPL) == 32'h0 &&
      ((cor_mask_reg | cor_stat_reg) & ~perc_pkg::COR_IMPL) == 32'h0)
      else $error("reserved bit became set");

   cor_status_set_a: assert property (
      (cor_live != 32'h0) |=> ((cor_stat_reg & $past(cor_live)) == $past(cor_live)))
      else $error("correctable event not recorded");

   cor_status_hold_a: assert property (
      (cor_live == 32'h0) && !(cfg_wr && hit(cfg_addr, perc_pkg::AER_BASE,
      perc_pkg::OFS_COR_STAT)) |=> $stable(cor_stat_reg))
      else $error("correctable status changed without cause");

   fep_lock_hold_a: assert property (
      fep_lock_reg && !fep_release && !func_rst |=> $stable(fep_reg) && $stable(hlog_reg))
      else $error("first error pointer overwritten");

   next_ptr_read_a: assert property (
      cfg_rd && hit(cfg_addr, perc_pkg::AER_BASE, perc_pkg::OFS_CAP_HDR) |=>
      cfg_rd_valid && (cfg_rdata[31:20] == ($past(dsn_en_reg) ? 12'h140 : 12'h000)))
      else $error("wrong next capability pointer");

   dsn_id_read_a: assert property (
      cfg_rd && dsn_en_reg && hit(cfg_addr, perc_pkg::DSN_BASE, perc_pkg::OFS_CAP_HDR)
      |=> cfg_rdata == 32'h00010003)
      else $error("serial capability header wrong");

   dsn_low_read_a: assert property (
      cfg_rd && dsn_en_reg && hit(cfg_addr, perc_pkg::DSN_BASE, perc_pkg::OFS_DSN_LO)
      |=> cfg_rdata == $past(serial_num[31:0]))
      else $error("serial lower dword wrong");

   sticky_func_rst_a: assert property (
      func_rst && !cfg_wr |=> $stable(unc_mask_reg) && $stable(unc_sev_reg) &&
      $stable(cor_mask_reg))
      else $error("sticky bit lost on function reset");

   // non-fatal needs an unmasked error with no fatal one beside it
   sequence unc_nonfatal_s;
      (|(unc_rep & ~unc_sev_reg)) && !(|(unc_rep & unc_sev_reg)) && !func_rst;
   endsequence

   nonfatal_report_a: assert property (unc_nonfatal_s |=> err_msg_valid &&
      (err_msg_kind == perc_pkg::MSG_NONFATAL))
      else $error("non-fatal error not reported as non-fatal");

   cor_report_a: assert property (
      (unc_rep == 32'h0) && ((cor_live & ~cor_mask_reg) != 32'h0) && !func_rst |=>
      err_msg_valid && (err_msg_kind == perc_pkg::MSG_COR))
      else $error("unmasked correctable error not reported");

   cor_mask_quiet_a: assert property (
      (cor_live != 32'h0) && ((cor_live & ~cor_mask_reg) == 32'h0) &&
      (unc_rep == 32'h0) |=> !err_msg_valid)
      else $error("masked correctable error produced a message");

   hlog_capture_a: assert property (
      !fep_lock_reg && (unc_live != 32'h0) && !func_rst |=>
      fep_lock_reg && (hlog_reg == $past(err_hdr)))
      else $error("header log missed the first error");

   func_rst_clear_a: assert property (
      func_rst |=> (fep_reg == perc_pkg::FEP_RST) && !fep_lock_reg &&
      (hlog_reg == 128'h0) && !err_msg_valid)
      else $error("function reset left pointer or log set");

   rd_valid_pulse_a: assert property (cfg_rd_valid == $past(cfg_rd))
      else $error("read answer not one cycle after request");

   dsn_high_read_a: assert property (
      cfg_rd && dsn_en_reg && hit(cfg_addr, perc_pkg::DSN_BASE, perc_pkg::OFS_DSN_HI)
      |=> cfg_rdata == $past(serial_num[63:32]))
      else $error("serial upper dword wrong");

   dsn_hidden_a: assert property (
      cfg_rd && !dsn_en_reg && hit(cfg_addr, perc_pkg::DSN_BASE, perc_pkg::OFS_CAP_HDR)
      |=> cfg_rdata == 32'h00000000)
      else $error("serial capability visible while disabled");

endmodule // perc_top

//--- testbench/perc_host_model.sv
// host bridge side model: takes and counts the error messages of the device
`timescale 1ns/100ps
module perc_host_model (
   // clock and power-on reset
   input wire logic mclk,
   input wire logic arst_n,
   // error message request from the device
   input wire logic err_msg_valid,
   input wire logic [1:0] err_msg_kind
);
   int msg_cnt; // messages taken since reset
   logic [1:0] last_kind; // kind of the latest message
   // never stalls, so a lost or doubled pulse shows up in the count
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         msg_cnt <= 0;
         last_kind <= 2'h0;
      end else if (err_msg_valid) begin
         msg_cnt <= msg_cnt + 1;
         last_kind <= err_msg_kind;
      end
   end
endmodule // perc_host_model

//--- testbench/pcie_error_report_and_serial_cap_tb_top.sv
// self-checking bench for the error reporting and serial number registers
`timescale 1ns/100ps
module pcie_error_report_and_serial_cap_tb_top;
   // ************************************************************************
   // signals, clock and instances
   // ************************************************************************
   logic mclk = 1'b0, arst_n = 1'b0, func_rst = 1'b0, cfg_rd = 1'b0, cfg_wr = 1'b0;
   logic [11:0] cfg_addr = 12'h000;
   logic [3:0] cfg_be = 4'hf;
   logic [31:0] cfg_wdata = 32'h0, cfg_rdata, unc_err_evt = 32'h0, cor_err_evt = 32'h0;
   logic [127:0] err_hdr = 128'h0, hdr;
   logic fep_release = 1'b0, dsn_enable_pin = 1'b0, cfg_rd_valid, err_msg_valid;
   logic [63:0] serial_num = 64'h0;
   perc_pkg::perc_msg_t err_msg_kind;
   int error_cnt = 0, total_checks = 0, exp_msgs = 0, cyc = 0;
   logic [31:0] seed = 32'h0000d800, r; // fixed seed keeps runs repeatable
   int ub[9] = '{4, 12, 13, 14, 15, 16, 17, 18, 20}; // uncorrectable sources
   int cb[6] = '{0, 6, 7, 8, 12, 13}; // correctable sources
   always #2.5 mclk = ~mclk; // 200 MHz
   perc_top dut (.mclk(mclk), .arst_n(arst_n), .func_rst(func_rst), .cfg_rd(cfg_rd),
      .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid), .unc_err_evt(unc_err_evt),
      .cor_err_evt(cor_err_evt), .err_hdr(err_hdr), .fep_release(fep_release),
      .serial_num(serial_num), .dsn_enable_pin(dsn_enable_pin),
      .err_msg_valid(err_msg_valid), .err_msg_kind(err_msg_kind));
   perc_host_model hm (.mclk(mclk), .arst_n(arst_n), .err_msg_valid(err_msg_valid),
      .err_msg_kind(err_msg_kind));
   // ************************************************************************
   // helpers
   // ************************************************************************
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // message kind that a severity pattern asks for at one source bit
   function automatic logic [1:0] kind_of(input logic [31:0] sev, input int b);
      return sev[b] ? 2'h2 : 2'h1;
   endfunction
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // all tasks start and end on a falling edge; wr, rd and ev add an idle cycle to avoid double drives, rel does not
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      cfg_be = be;
      @(negedge mclk);
      cfg_wr = 1'b0;
      @(negedge mclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      cfg_rd = 1'b1;
      cfg_addr = a;
      @(negedge mclk);
      cfg_rd = 1'b0;
      chk(cfg_rd_valid, 1'b1);
      chk(cfg_rdata, exp);
      @(negedge mclk);
   endtask
   // one-cycle error event, message expected one cycle later and for one cycle
   task automatic ev(input logic [31:0] u, input logic [31:0] c, input logic v,
                     input logic [1:0] k);
      unc_err_evt = u;
      cor_err_evt = c;
      @(negedge mclk);
      unc_err_evt = 32'h0;
      cor_err_evt = 32'h0;
      chk(err_msg_valid, v);
      if (v) begin
         chk(err_msg_kind, k);
         exp_msgs++;
      end
      @(negedge mclk);
      chk(err_msg_valid, 1'b0);
   endtask
   task automatic rel();
      fep_release = 1'b1;
      @(negedge mclk);
      fep_release = 1'b0;
   endtask
   // hang guard, far above the few hundred cycles the sequence needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end
   // ************************************************************************
   // main sequence
   // ************************************************************************
   initial begin
      repeat (5) @(negedge mclk);
      arst_n = 1'b1;
      // power-on values, hole at 0x104 and an unmapped place
      rd(12'h100, 32'h00010001);
      rd(12'h104, 32'h0);
      rd(12'h108, 32'h0);
      rd(12'h10c, 32'h00062010);
      rd(12'h110, 32'h0);
      rd(12'h114, 32'h00002000);
      for (int i = 0; i < 7; i++) rd(12'h118 + 12'(4 * i), 32'h0);
      rd(12'h200, 32'h0);
      rd(12'h140, 32'h0);
      // byte enables, reserved bits, masked error, sticky across function reset
      wr(12'h108, 32'hffffffff, 4'h2);
      rd(12'h108, 32'h0000f000);
      wr(12'h108, 32'hffffffff, 4'hf);
      rd(12'h108, 32'h0017f010);
      ev(32'h10, 32'h0, 1'b0, 2'h0);
      func_rst = 1'b1;
      @(negedge mclk);
      func_rst = 1'b0;
      rd(12'h108, 32'h0017f010);
      rd(12'h118, 32'h0);
      wr(12'h108, 32'h0, 4'hf);
      // random severity and correctable mask patterns
      for (int i = 0; i < 8; i++) begin
         r = xs();
         wr(12'h10c, r, 4'hf);
         rd(12'h10c, r & 32'h0017f010);
         wr(12'h114, r, 4'hf);
         rd(12'h114, r & 32'h000031c1);
      end
      wr(12'h114, 32'h0, 4'hf);
      // every uncorrectable source: kind from severity, pointer and header log
      foreach (ub[i]) begin
         r = xs();
         hdr = {xs(), xs(), xs(), xs()};
         wr(12'h10c, r, 4'hf);
         rel();
         err_hdr = hdr;
         ev(32'h1 << ub[i], 32'h0, 1'b1, kind_of(r, ub[i]));
         rd(12'h118, 32'(ub[i][3:0]));
         for (int j = 0; j < 4; j++) rd(12'h11c + 12'(4 * j), hdr[32 * j +: 32]);
      end
      // a later error must not move the locked pointer or log
      err_hdr = ~hdr;
      ev(32'h00002000, 32'h0, 1'b1, kind_of(r, 13));
      rd(12'h118, 32'h4);
      rd(12'h11c, hdr[31:0]);
      // correctable sources, write-one-clear, masking, priority
      wr(12'h10c, 32'h00000010, 4'hf);
      foreach (cb[i]) ev(32'h0, 32'h1 << cb[i], 1'b1, 2'h0);
      rd(12'h110, 32'h000031c1);
      wr(12'h110, 32'h0, 4'hf);
      rd(12'h110, 32'h000031c1);
      wr(12'h110, 32'h00000041, 4'hf);
      rd(12'h110, 32'h00003180);
      wr(12'h114, 32'h000031c1, 4'hf);
      ev(32'h0, 32'h1, 1'b0, 2'h0);
      rd(12'h110, 32'h00003181);
      wr(12'h114, 32'h0, 4'hf);
      ev(32'h10, 32'h40, 1'b1, 2'h2);
      // serial number capability behind the synchronised enable
      serial_num = {xs(), xs()};
      dsn_enable_pin = 1'b1;
      repeat (3) @(negedge mclk);
      rd(12'h100, 32'h14010001);
      rd(12'h140, 32'h00010003);
      rd(12'h144, serial_num[31:0]);
      rd(12'h148, serial_num[63:32]);
      dsn_enable_pin = 1'b0;
      repeat (3) @(negedge mclk);
      rd(12'h100, 32'h00010001);
      chk(hm.msg_cnt, exp_msgs);
      chk(hm.last_kind, 2'h2);
      give_verdict();
   end
endmodule // pcie_error_report_and_serial_cap_tb_top
